//--- verilog/vpic_pkg.sv
package vpic_pkg;
	localparam int N_IRQ = 41;
	localparam int FLAG_WORDS = 3;
	localparam int PRI_WORDS = 11;
	localparam int WORD_W = 16;
	localparam int PRI_W = 3;
	localparam int IRQ_W = 6;
	localparam int VEC_W = 8;
	localparam int ADDR_W = 24;
	localparam int N_TRAP = 7;
	localparam int SRC_PER_FLAG_WORD = 16;
	localparam int SRC_PER_PRI_WORD = 4;
	localparam int PRI_FIELD_STRIDE = 4;
	localparam int RESERVED_IRQ = 15;
	localparam int CAN_1_RX_READY_IRQ = 34;
	localparam int CAN_1_EVENT_IRQ = 35;
	localparam logic CAN_PRESENT = 1'b1;
	localparam logic [VEC_W-1:0] FIRST_IRQ_VECTOR = 8'h08;
	localparam logic [VEC_W-1:0] FIRST_TRAP_VECTOR = 8'h01;
	localparam logic [ADDR_W-1:0] TABLE_BASE = 24'h000004;
	localparam logic [ADDR_W-1:0] RESET_PC = 24'h000000;
	localparam logic [3:0] ENTRY_CYCLES = 4'h4;
	localparam logic [3:0] RETURN_CYCLES = 4'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_HANDLER, ST_RETURN} vpic_state_type;

	function automatic int flag_index(input int irq);
		return (irq / SRC_PER_FLAG_WORD) * WORD_W + (irq % SRC_PER_FLAG_WORD);
	endfunction : flag_index

	function automatic int pri_word(input int irq);
		return irq / SRC_PER_PRI_WORD;
	endfunction : pri_word

	function automatic int pri_lsb(input int irq);
		return (irq % SRC_PER_PRI_WORD) * PRI_FIELD_STRIDE;
	endfunction : pri_lsb

	function automatic logic irq_present(input int irq);
		return (irq < N_IRQ) && (irq != RESERVED_IRQ) &&
			(CAN_PRESENT || ((irq != CAN_1_RX_READY_IRQ) && (irq != CAN_1_EVENT_IRQ)));
	endfunction : irq_present
endpackage : vpic_pkg

//--- verilog/vpic_arb_if.sv
`timescale 1ns/1ps
interface vpic_arb_if;
	logic [vpic_pkg::N_IRQ-1:0] pend;
	logic [vpic_pkg::N_IRQ-1:0][vpic_pkg::PRI_W-1:0] prio;
	logic win_valid;
	logic [vpic_pkg::IRQ_W-1:0] win_irq;
	logic [vpic_pkg::PRI_W-1:0] win_pri;
	modport arb (input pend, input prio, output win_valid, output win_irq, output win_pri);
	modport ctrl (output pend, output prio, input win_valid, input win_irq, input win_pri);
endinterface : vpic_arb_if

//--- verilog/vpic_arbiter.sv
`timescale 1ns/1ps
module vpic_arbiter
(
	vpic_arb_if.arb a
);
	// Scan from the top so an equal level at a lower index overwrites
	// Fixed order inside one level
	always_comb
	begin
		a.win_valid = 1'b0;
		a.win_irq = '0;
		a.win_pri = '0;
		for (int i = vpic_pkg::N_IRQ - 1; i >= 0; i--)
		begin
			if (a.pend[i] && (!a.win_valid || (a.prio[i] >= a.win_pri)))
			begin
				a.win_valid = 1'b1;
				a.win_irq = vpic_pkg::IRQ_W'(i);
				a.win_pri = a.prio[i];
			end
		end
	end
endmodule : vpic_arbiter

//--- verilog/vpic_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - Merge all sources into one request
// - Eight levels, 3-bit field per source
// - Equal levels resolved by fixed order
// - Constant entry and return latency
// - Table starts at word 000004h
// - Seven traps, up to 40 maskable
// - Up to seven exception sources
// - Entry yields 24-bit handler address
// - Lower vector position wins at equal level
// - Reset clears state, program counter zero
// - External line 0 is vector 8
// - Four priority fields per register
// - Sixteen flag bits per register
// - Request 16 wraps to second word
// - CAN sources only on CAN variants
module vpic_ctrl
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Peripheral side
	input wire logic [vpic_pkg::N_IRQ-1:0] IRQ_EVENT,
	input wire logic [vpic_pkg::N_TRAP-1:0] TRAP_REQ,
	input wire logic [vpic_pkg::FLAG_WORDS-1:0][vpic_pkg::WORD_W-1:0] IRQ_FLAG_CLEAR,
	input wire logic [vpic_pkg::FLAG_WORDS-1:0][vpic_pkg::WORD_W-1:0] IRQ_ENABLE,
	input wire logic [vpic_pkg::PRI_WORDS-1:0][vpic_pkg::WORD_W-1:0] IRQ_PRIORITY_CONTROL,
	output logic [vpic_pkg::FLAG_WORDS-1:0][vpic_pkg::WORD_W-1:0] IRQ_FLAG_STATUS,
	// CPU side
	input wire logic [vpic_pkg::PRI_W-1:0] CPU_PRIORITY,
	input wire logic CPU_ACCEPT,
	input wire logic RETURN_REQ,
	input wire logic [vpic_pkg::ADDR_W-1:0] TABLE_DATA,
	output logic IRQ_REQUEST,
	output logic [vpic_pkg::VEC_W-1:0] VECTOR_NUM,
	output logic [vpic_pkg::ADDR_W-1:0] TABLE_ADDR,
	output logic [vpic_pkg::ADDR_W-1:0] HANDLER_PC,
	output logic ENTER_HANDLER,
	output logic RESUME
);
	localparam int FLAG_BITS = vpic_pkg::FLAG_WORDS * vpic_pkg::WORD_W;

	vpic_arb_if bus ();
	vpic_arbiter u_arb (.a(bus));

	logic [FLAG_BITS-1:0] flag_q;
	wire logic [FLAG_BITS-1:0] flag_d;
	wire logic [FLAG_BITS-1:0] clr_flat;
	wire logic [FLAG_BITS-1:0] en_flat;
	vpic_pkg::vpic_state_type state_q;
	logic [3:0] cnt_q;
	logic irq_q;
	logic [vpic_pkg::VEC_W-1:0] vec_q;
	logic [vpic_pkg::ADDR_W-1:0] addr_q;
	logic [vpic_pkg::ADDR_W-1:0] pc_q;
	logic enter_q;
	logic resume_q;

	assign clr_flat = IRQ_FLAG_CLEAR;
	assign en_flat = IRQ_ENABLE;

	genvar g;
	generate
		for (g = 0; g < FLAG_BITS; g++)
		begin : g_flag
			localparam int IRQ = (g / vpic_pkg::WORD_W) * vpic_pkg::SRC_PER_FLAG_WORD + (g % vpic_pkg::WORD_W);
			if (vpic_pkg::irq_present(IRQ))
			begin : g_impl
				// Set wins over a same-cycle clear
				assign flag_d[g] = IRQ_EVENT[IRQ] | (flag_q[g] & ~clr_flat[g]);
			end
			else
			begin : g_none
				// Absent sources never hold a flag
				assign flag_d[g] = 1'b0;
			end
		end
		for (g = 0; g < vpic_pkg::N_IRQ; g++)
		begin : g_src
			// Word and bit come from request number
			assign bus.pend[g] = flag_q[vpic_pkg::flag_index(g)] & en_flat[vpic_pkg::flag_index(g)];
			assign bus.prio[g] = IRQ_PRIORITY_CONTROL[vpic_pkg::pri_word(g)][vpic_pkg::pri_lsb(g) +: vpic_pkg::PRI_W];
		end
	endgenerate

	// Lowest trap index is taken first
	// Seven non-maskable trap vectors
	function automatic logic [vpic_pkg::VEC_W-1:0] trap_vector(input logic [vpic_pkg::N_TRAP-1:0] req);
		logic [vpic_pkg::VEC_W-1:0] v;
		v = vpic_pkg::FIRST_TRAP_VECTOR;
		for (int i = vpic_pkg::N_TRAP - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				v = vpic_pkg::FIRST_TRAP_VECTOR + vpic_pkg::VEC_W'(i);
			end
		end
		return v;
	endfunction : trap_vector

	wire logic trap_any = |TRAP_REQ;
	wire logic [vpic_pkg::VEC_W-1:0] trap_vec = trap_vector(TRAP_REQ);
	// Only a level above the CPU's may request
	wire logic irq_ok = bus.win_valid && (bus.win_pri > CPU_PRIORITY);
	// Traps are not maskable and outrank every source
	wire logic req_valid = trap_any | irq_ok;
	// Request 0 maps to vector 8
	wire logic [vpic_pkg::VEC_W-1:0] req_vec = trap_any ? trap_vec :
		vpic_pkg::FIRST_IRQ_VECTOR + vpic_pkg::VEC_W'(bus.win_irq);
	wire logic accept = (state_q == vpic_pkg::ST_IDLE) && irq_q && CPU_ACCEPT;
	// Two program words per entry above the base
	wire logic [vpic_pkg::ADDR_W-1:0] entry_addr = vpic_pkg::TABLE_BASE + {15'h0000, vec_q, 1'b0};

	// Reset clears everything, handler address is zero
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			flag_q <= '0;
		end
		else
		begin
			flag_q <= flag_d;
		end
	end

	// No nesting: a new request waits until the current return completes
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_q <= vpic_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			irq_q <= 1'b0;
			vec_q <= 8'h00;
			addr_q <= vpic_pkg::RESET_PC;
			pc_q <= vpic_pkg::RESET_PC;
			enter_q <= 1'b0;
			resume_q <= 1'b0;
		end
		else
		begin
			enter_q <= 1'b0;
			resume_q <= 1'b0;
			unique case (state_q)
				vpic_pkg::ST_IDLE:
				begin
					if (accept)
					begin
						irq_q <= 1'b0;
						addr_q <= entry_addr;
						cnt_q <= vpic_pkg::ENTRY_CYCLES - 4'h1;
						state_q <= vpic_pkg::ST_ENTRY;
					end
					else
					begin
						irq_q <= req_valid;
						vec_q <= req_vec;
					end
				end
				vpic_pkg::ST_ENTRY:
				begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0)
					begin
						// Handler address from the table word
						pc_q <= TABLE_DATA;
						enter_q <= 1'b1;
						state_q <= vpic_pkg::ST_HANDLER;
					end
				end
				vpic_pkg::ST_HANDLER:
				begin
					if (RETURN_REQ)
					begin
						cnt_q <= vpic_pkg::RETURN_CYCLES - 4'h1;
						state_q <= vpic_pkg::ST_RETURN;
					end
				end
				vpic_pkg::ST_RETURN:
				begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0)
					begin
						resume_q <= 1'b1;
						state_q <= vpic_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	assign IRQ_FLAG_STATUS = flag_q;
	// Single registered request toward the core
	assign IRQ_REQUEST = irq_q;
	assign VECTOR_NUM = vec_q;
	assign TABLE_ADDR = addr_q;
	assign HANDLER_PC = pc_q;
	assign ENTER_HANDLER = enter_q;
	assign RESUME = resume_q;

	chk_irq_follows_cause: assert property (@(posedge CLK) disable iff (RST)
		(state_q == vpic_pkg::ST_IDLE && !accept) |=> (IRQ_REQUEST == $past(req_valid)))
		else $error("request does not follow pending state");
	chk_entry_latency: assert property (@(posedge CLK) disable iff (RST)
		accept |-> ##5 ENTER_HANDLER)
		else $error("entry latency wrong");
	chk_return_latency: assert property (@(posedge CLK) disable iff (RST)
		(state_q == vpic_pkg::ST_HANDLER && RETURN_REQ) |-> (!RESUME [*4] ##1 RESUME))
		else $error("return latency wrong");
	chk_table_addr_map: assert property (@(posedge CLK) disable iff (RST)
		accept |=> (TABLE_ADDR == vpic_pkg::TABLE_BASE + 24'($past(vec_q)) * 24'h000002))
		else $error("table address mismatch");
	chk_handler_load: assert property (@(posedge CLK) disable iff (RST)
		(state_q == vpic_pkg::ST_ENTRY && cnt_q == 4'h0) |=> (HANDLER_PC == $past(TABLE_DATA)))
		else $error("handler address not loaded");
	chk_flag_set_wins: assert property (@(posedge CLK) disable iff (RST)
		IRQ_EVENT[10] |=> IRQ_FLAG_STATUS[0][10])
		else $error("flag event lost");
	chk_wrap_second_word: assert property (@(posedge CLK) disable iff (RST)
		IRQ_EVENT[16] |=> IRQ_FLAG_STATUS[1][0])
		else $error("request 16 not in second word");
	chk_trap_outranks: assert property (@(posedge CLK) disable iff (RST)
		(state_q == vpic_pkg::ST_IDLE && !accept && trap_any) |=> (IRQ_REQUEST && VECTOR_NUM < vpic_pkg::FIRST_IRQ_VECTOR))
		else $error("trap did not win");
	chk_fixed_order: assert property (@(posedge CLK) disable iff (RST)
		(bus.pend[0] && bus.prio[0] == bus.win_pri) |-> (bus.win_irq == 6'h00))
		else $error("lower vector lost tie");
	chk_winner_pending: assert property (@(posedge CLK) disable iff (RST)
		bus.win_valid |-> (bus.pend[bus.win_irq] && bus.prio[bus.win_irq] == bus.win_pri))
		else $error("winner not pending");
	chk_prio_field: assert property (@(posedge CLK) disable iff (RST)
		bus.prio[4] == IRQ_PRIORITY_CONTROL[1][2:0])
		else $error("priority field misplaced");
	chk_reserved_flag: assert property (@(posedge CLK) disable iff (RST)
		!IRQ_FLAG_STATUS[0][15])
		else $error("reserved flag set");
	chk_reset_pc: assert property (@(posedge CLK)
		$past(RST) |-> (HANDLER_PC == vpic_pkg::RESET_PC && !IRQ_REQUEST))
		else $error("reset state wrong");
	chk_request_line0: assert property (@(posedge CLK) disable iff (RST)
		(state_q == vpic_pkg::ST_IDLE && !accept && !trap_any && irq_ok && bus.win_irq == 6'h00)
		|=> (VECTOR_NUM == 8'h08))
		else $error("line 0 vector wrong");

	cov_entry: cover property (@(posedge CLK) disable iff (RST) accept ##5 ENTER_HANDLER);
	cov_resume: cover property (@(posedge CLK) disable iff (RST) RESUME);
	cov_trap: cover property (@(posedge CLK) disable iff (RST) trap_any && irq_ok);
	cov_tie: cover property (@(posedge CLK) disable iff (RST) bus.pend[0] && bus.pend[1] && bus.prio[0] == bus.prio[1]);
endmodule : vpic_ctrl

//--- tb/vpic_cpu_model.sv
`timescale 1ns/1ps
module vpic_cpu_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Controller side
	input wire logic irq_request,
	input wire logic enter_handler,
	input wire logic [23:0] table_addr,
	output logic cpu_accept,
	output logic return_req,
	output logic [23:0] table_data,
	// Bench control
	input wire logic go,
	input wire logic [3:0] dly
);
	logic [3:0] cnt_q;
	logic busy_q;
	// Distinct handler per slot, so a wrong slot shows
	assign table_data = {table_addr[11:0], ~table_addr[11:0]};
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cpu_accept <= 1'b0;
			return_req <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
		end
		else
		begin
			cpu_accept <= irq_request && go;
			return_req <= busy_q && cnt_q == 4'h0;
			if (enter_handler)
			begin
				busy_q <= 1'b1;
				cnt_q <= dly;
			end
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			else
				busy_q <= 1'b0;
		end
	end
endmodule : vpic_cpu_model

//--- tb/test_vpic_ctrl.sv
`timescale 1ns/1ps
module test_vpic_ctrl;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [40:0] IRQ_EVENT = '0;
	logic [6:0] TRAP_REQ = '0;
	logic [2:0][15:0] IRQ_FLAG_CLEAR = '0, IRQ_ENABLE = '0, IRQ_FLAG_STATUS, exp_flag;
	logic [10:0][15:0] IRQ_PRIORITY_CONTROL = '0;
	logic [2:0] CPU_PRIORITY = '0;
	logic CPU_ACCEPT, RETURN_REQ, IRQ_REQUEST, ENTER_HANDLER, RESUME, go = 1'b0;
	logic [7:0] VECTOR_NUM, exp_vec;
	logic [23:0] TABLE_DATA, TABLE_ADDR, HANDLER_PC, exp_addr;
	logic [3:0] dly = 4'h0;
	logic [2:0] pri [41];
	logic [40:0] pend;
	logic [31:0] seed = 32'hea74;
	int n_errors = 0, check_count = 0, cyc = 0, lat = 0, rlat = 0;
	int corner [7] = '{0, 4, 10, 16, 15, 40, 34};

	vpic_ctrl u_vpic_ctrl (.CLK(CLK), .RST(RST), .IRQ_EVENT(IRQ_EVENT), .TRAP_REQ(TRAP_REQ),
		.IRQ_FLAG_CLEAR(IRQ_FLAG_CLEAR), .IRQ_ENABLE(IRQ_ENABLE), .IRQ_PRIORITY_CONTROL(IRQ_PRIORITY_CONTROL),
		.IRQ_FLAG_STATUS(IRQ_FLAG_STATUS), .CPU_PRIORITY(CPU_PRIORITY), .CPU_ACCEPT(CPU_ACCEPT),
		.RETURN_REQ(RETURN_REQ), .TABLE_DATA(TABLE_DATA), .IRQ_REQUEST(IRQ_REQUEST), .VECTOR_NUM(VECTOR_NUM),
		.TABLE_ADDR(TABLE_ADDR), .HANDLER_PC(HANDLER_PC), .ENTER_HANDLER(ENTER_HANDLER), .RESUME(RESUME));
	vpic_cpu_model u_vpic_cpu_model (.clk(CLK), .rst(RST), .irq_request(IRQ_REQUEST),
		.enter_handler(ENTER_HANDLER), .table_addr(TABLE_ADDR), .cpu_accept(CPU_ACCEPT),
		.return_req(RETURN_REQ), .table_data(TABLE_DATA), .go(go), .dly(dly));

	always #12.5 CLK = ~CLK;
	// Cycles since accept and since return request
	always @(posedge CLK)
	begin
		cyc++;
		lat = (CPU_ACCEPT && IRQ_REQUEST) ? 0 : lat + 1;
		rlat = RETURN_REQ ? 0 : rlat + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			results();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] expect_vec();
		logic [2:0] best;
		logic [7:0] v;
		best = CPU_PRIORITY;
		v = 8'h00;
		for (int i = 6; i >= 0; i--)
			if (TRAP_REQ[i])
				v = 8'h01 + 8'(i);
		if (v != 8'h00)
			return v;
		// Ascending scan with strict compare keeps the lowest on ties
		for (int i = 0; i < 41; i++)
			if (pend[i] && i != 15 && IRQ_ENABLE[i / 16][i % 16] && pri[i] > best)
			begin
				best = pri[i];
				v = 8'h08 + 8'(i);
			end
		return v;
	endfunction : expect_vec

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic results();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic wait_neg(input bit for_resume);
		for (int k = 0; k < 30 && !(for_resume ? RESUME : ENTER_HANDLER); k++)
			@(negedge CLK);
	endtask : wait_neg

	task automatic one(input int a, input int b, input logic [6:0] trap);
		logic [10:0][15:0] pc;
		pc = '0;
		for (int i = 0; i < 41; i++)
			pc[i / 4][(i % 4) * 4 +: 3] = pri[i];
		pend = '0;
		pend[a] = 1'b1;
		pend[b] = 1'b1;
		@(posedge CLK);
		IRQ_PRIORITY_CONTROL <= pc;
		@(posedge CLK);
		IRQ_EVENT <= pend;
		TRAP_REQ <= trap;
		// Clear rides with the event: the set must win
		IRQ_FLAG_CLEAR <= '1;
		@(posedge CLK);
		IRQ_EVENT <= '0;
		IRQ_FLAG_CLEAR <= '0;
		repeat (2) @(negedge CLK);
		exp_flag = '0;
		for (int i = 0; i < 41; i++)
			exp_flag[i / 16][i % 16] = pend[i] && i != 15;
		chk(IRQ_FLAG_STATUS, exp_flag);
		exp_vec = expect_vec();
		chk(IRQ_REQUEST, exp_vec != 8'h00);
		if (exp_vec != 8'h00)
		begin
			chk(VECTOR_NUM, exp_vec);
			@(posedge CLK);
			go <= 1'b1;
			wait_neg(1'b0);
			exp_addr = vpic_pkg::TABLE_BASE + 24'(exp_vec) * 24'h000002;
			chk(ENTER_HANDLER, 1'b1);
			chk(32'(lat), vpic_pkg::ENTRY_CYCLES);
			chk(TABLE_ADDR, exp_addr);
			chk(HANDLER_PC, {exp_addr[11:0], ~exp_addr[11:0]});
		end
		@(posedge CLK);
		go <= 1'b0;
		TRAP_REQ <= '0;
		IRQ_FLAG_CLEAR <= '1;
		@(posedge CLK);
		IRQ_FLAG_CLEAR <= '0;
		if (exp_vec != 8'h00)
		begin
			wait_neg(1'b1);
			chk(RESUME, 1'b1);
			chk(32'(rlat), vpic_pkg::RETURN_CYCLES);
		end
	endtask : one

	initial
	begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		@(negedge CLK);
		chk(IRQ_FLAG_STATUS, 64'h0);
		chk({IRQ_REQUEST, ENTER_HANDLER, RESUME, TABLE_ADDR, HANDLER_PC}, 64'h0);
		for (int it = 0; it < 70; it++)
		begin
			for (int i = 0; i < 41; i++)
			begin
				seed = lfsr(seed);
				pri[i] = seed[2:0];
			end
			seed = lfsr(seed);
			@(posedge CLK);
			IRQ_ENABLE <= it < 8 ? '1 : {seed, seed[15:0]};
			CPU_PRIORITY <= it < 8 ? 3'h0 : seed[30:28];
			dly <= seed[27:24];
			if (it < 7)
			begin
				pri[corner[it]] = 3'h5;
				// Request 1 ties request 0 at one level in the first corner
				pri[1] = 3'h5;
				one(corner[it], it == 0 ? 1 : corner[it], 7'h00);
			end
			else
				one(seed[15:0] % 41, seed[31:16] % 41, it == 7 ? 7'h06 : seed[7:5] == 3'h0 ? seed[14:8] : 7'h00);
		end
		results();
	end
endmodule : test_vpic_ctrl
